//--- design/iga_aggregator.sv
// iga_aggregator.sv: two event aggregation groups (a and b) for the controller core
// assumes event inputs come from logic on mclk_in and the core's bus is synchronous
`include "iga_params.svh"
`default_nettype none

module iga_aggregator (
  // clock and reset
  input  wire logic               mclk_in,
  input  wire logic               reset_in,
  // register bus from the core
  input  wire logic               bus_sel_in,
  input  wire logic               bus_wr_in,
  input  wire iga_pkg::iga_addr_t bus_addr_in,
  input  wire iga_pkg::iga_word_t bus_wdata_in,
  output var  iga_pkg::iga_word_t bus_rdata_out,
  // group a event sources
  input  wire iga_pkg::iga_a_ev_t event_group_a_in,
  // group b event sources
  input  wire logic               identification_done_event_in,
  input  wire logic               converter_single_done_in,
  input  wire logic               converter_repeat_done_in,
  input  wire logic               thermal_link_event_in,
  // requests to the core
  output var  logic               event_group_a_irq_out,
  output var  logic               event_group_b_irq_out
);
  import iga_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  iga_word_t src_a_q;      // group a source
  iga_word_t en_a_q;       // group a enable
  logic      hint_a_q;     // leading_bit_hint of group a result
  iga_word_t src_b_q;      // group b source
  logic      id_done_q;    // previous identification done level
  iga_word_t res_a;        // group a masked result
  iga_word_t ev_a;         // group a events as a word
  iga_word_t ev_b;         // group b events as a word
  logic      wr_src_a;     // write to group a source
  logic      wr_src_b;     // write to group b source
  logic      wr_en_a;      // write to group a enable
  logic      wr_res_a;     // write to group a result, hint bit only

  // write strobe for one offset
  function automatic logic wr_hit(input iga_addr_t off);
    wr_hit = bus_sel_in && bus_wr_in && (bus_addr_in == off);
  endfunction : wr_hit

  // latch-and-clear step; set wins over clear
  function automatic iga_word_t rwc(input iga_word_t cur, input iga_word_t set,
                                    input logic clr, input iga_word_t w,
                                    input iga_word_t defm);
    rwc = ((clr ? (cur & ~w) : cur) | set) & defm;
  endfunction : rwc

  // ---------------------------------------------------------------
  // event mapping
  // ---------------------------------------------------------------
  always_comb begin
    ev_a = `IGA_ZERO_WORD;
    ev_a[`IGA_A_NBITS-1:0] = event_group_a_in;
    ev_b = `IGA_ZERO_WORD;
    ev_b[`IGA_B_ID_BIT]      = identification_done_event_in & ~id_done_q;
    ev_b[`IGA_B_SINGLE_BIT]  = converter_single_done_in;
    ev_b[`IGA_B_REPEAT_BIT]  = converter_repeat_done_in;
    ev_b[`IGA_B_THERMAL_BIT] = thermal_link_event_in;
    // one strobe per writable register
    wr_src_a = wr_hit(`IGA_OFF_A_SOURCE);
    wr_src_b = wr_hit(`IGA_OFF_B_SOURCE);
    wr_en_a  = wr_hit(`IGA_OFF_A_ENABLE);
    wr_res_a = wr_hit(`IGA_OFF_A_RESULT);
    res_a = src_a_q & en_a_q;
  end

  // edge reference for identification done
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      id_done_q <= 1'b0;
    end else begin
      id_done_q <= identification_done_event_in;
    end
  end

  // group a source: reserved bits held at zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      src_a_q <= `IGA_ZERO_WORD;
    end else begin
      src_a_q <= rwc(src_a_q, ev_a, wr_src_a, bus_wdata_in, `IGA_A_DEFINED);
    end
  end

  // group b source
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      src_b_q <= `IGA_ZERO_WORD;
    end else begin
      src_b_q <= rwc(src_b_q, ev_b, wr_src_b, bus_wdata_in, `IGA_B_DEFINED);
    end
  end

  // group a enable: only defined bits writable
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      en_a_q <= `IGA_ZERO_WORD;
    end else if (wr_en_a) begin
      en_a_q <= bus_wdata_in & `IGA_A_DEFINED;
    end
  end

  // leading bit hint flag in group a result
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hint_a_q <= 1'b0;
    end else if (wr_res_a) begin
      hint_a_q <= bus_wdata_in[`IGA_HINT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read path, registered
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_rdata_out <= `IGA_ZERO_WORD;
    end else if (bus_sel_in && !bus_wr_in) begin
      unique case (bus_addr_in)
        `IGA_OFF_A_SOURCE: bus_rdata_out <= src_a_q;
        `IGA_OFF_A_ENABLE: bus_rdata_out <= en_a_q;
        `IGA_OFF_A_RESULT: bus_rdata_out <= {hint_a_q, res_a[`IGA_HINT_BIT-1:0]};
        `IGA_OFF_B_SOURCE: bus_rdata_out <= src_b_q;
        default:           bus_rdata_out <= `IGA_ZERO_WORD; // unmapped
      endcase
    end
  end

  // ---------------------------------------------------------------
  // requests to the core
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      event_group_a_irq_out <= 1'b0;
      event_group_b_irq_out <= 1'b0;
    end else begin
      event_group_a_irq_out <= |res_a;
      event_group_b_irq_out <= |src_b_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // clear write of group a bit0 with no competing event
  sequence s_clear_write_a;
    wr_src_a && bus_wdata_in[0] && !event_group_a_in[0];
  endsequence

  // group a bit0: set by its event, cleared by a write of one
  a_src_a_set: assert property (@(posedge mclk_in) disable iff (reset_in)
    event_group_a_in[0] |=> src_a_q[0])
    else $error("group a bit0 not latched");
  a_src_a_clear: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_clear_write_a |=> !src_a_q[0])
    else $error("group a bit0 not cleared");
  // group a bit2 holds until software writes the register
  a_src_a_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
    src_a_q[2] && !wr_src_a |=> src_a_q[2])
    else $error("group a bit2 lost");
  // reserved source bits never read as one
  a_reserved_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
    src_a_q[31:3] == 29'h0 && src_b_q[31:4] == 28'h0)
    else $error("reserved source bit set");
  // enable write keeps only the defined mask bits
  a_enable_mask: assert property (@(posedge mclk_in) disable iff (reset_in)
    wr_en_a |=> en_a_q == ($past(bus_wdata_in) & `IGA_A_DEFINED))
    else $error("enable write wrong");
  // hint bit follows the top bit of a result write
  a_hint_write: assert property (@(posedge mclk_in) disable iff (reset_in)
    wr_res_a |=> hint_a_q == $past(bus_wdata_in[`IGA_HINT_BIT]))
    else $error("hint bit write wrong");
  // result read returns source masked by enable below the hint bit
  a_result_read: assert property (@(posedge mclk_in) disable iff (reset_in)
    bus_sel_in && !bus_wr_in && bus_addr_in == `IGA_OFF_A_RESULT
      |=> bus_rdata_out[`IGA_HINT_BIT-1:0]
          == $past(src_a_q[`IGA_HINT_BIT-1:0] & en_a_q[`IGA_HINT_BIT-1:0]))
    else $error("result read wrong");
  // a level still high after its edge must not set bit0 again;
  // the first cycle after reset is left out, the edge reference was cleared
  a_id_edge: assert property (@(posedge mclk_in) disable iff (reset_in)
    !$past(reset_in) && !src_b_q[0] && !wr_src_b
      && $past(identification_done_event_in) && identification_done_event_in
      |=> !src_b_q[0])
    else $error("level set identification bit");
  // single conversion event lands in bit1 of group b
  a_b_single: assert property (@(posedge mclk_in) disable iff (reset_in)
    converter_single_done_in |=> src_b_q[`IGA_B_SINGLE_BIT])
    else $error("single conversion bit not latched");
  a_b_thermal: assert property (@(posedge mclk_in) disable iff (reset_in)
    thermal_link_event_in |=> src_b_q[3] ##1 (src_b_q[3] || $past(wr_src_b)))
    else $error("thermal bit not latched");
  // request lines follow their groups one cycle late
  a_irq_a_follow: assert property (@(posedge mclk_in) disable iff (reset_in)
    ##1 event_group_a_irq_out == |$past(src_a_q & en_a_q))
    else $error("group a request wrong");
  a_irq_b_follow: assert property (@(posedge mclk_in) disable iff (reset_in)
    converter_single_done_in |-> ##2 event_group_b_irq_out || $past(wr_src_b))
    else $error("group b request missing");
  a_irq_b_level: assert property (@(posedge mclk_in) disable iff (reset_in)
    ##1 event_group_b_irq_out == |$past(src_b_q))
    else $error("group b request wrong");
endmodule : iga_aggregator

`default_nettype wire

//--- design/iga_params.svh
// iga_params.svh: offsets, field positions and reset values of the event group aggregator
// assumes inclusion by the aggregator package and design file only
`ifndef IGA_PARAMS_SVH
`define IGA_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets on the controller peripheral bus
// ---------------------------------------------------------------
`define IGA_OFF_A_SOURCE 8'h8c
`define IGA_OFF_A_ENABLE 8'h90
`define IGA_OFF_A_RESULT 8'h94
`define IGA_OFF_B_SOURCE 8'ha0

// ---------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------
`define IGA_A_DEFINED    32'h0000_0007
`define IGA_B_DEFINED    32'h0000_000f
`define IGA_HINT_BIT     31
`define IGA_ZERO_WORD    32'h0000_0000
`define IGA_A_NBITS      3
`define IGA_B_NBITS      4
`define IGA_B_ID_BIT      0
`define IGA_B_SINGLE_BIT  1
`define IGA_B_REPEAT_BIT  2
`define IGA_B_THERMAL_BIT 3

`endif

//--- design/iga_pkg.sv
// iga_pkg.sv: types shared by the event group aggregator
// assumes iga_params.svh is on the include path
`include "iga_params.svh"
`default_nettype none

package iga_pkg;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [31:0] iga_word_t;      // one register word
  typedef logic [7:0]  iga_addr_t;      // register offset
  typedef logic [`IGA_A_NBITS-1:0] iga_a_ev_t; // group a event lines
  typedef logic [`IGA_B_NBITS-1:0] iga_b_ev_t; // group b event lines
endpackage : iga_pkg

`default_nettype wire

//--- tb/iga_event_src.sv
// iga_event_src.sv: model of the peripheral event sources that feed the aggregator
// assumes the bench drives fire_in just after the rising edge of mclk_in
`default_nettype none
module iga_event_src (
  // clock and requests from the bench
  input  wire logic       mclk_in,
  input  wire logic [6:0] fire_in,
  // event lines to the aggregator
  output var  logic [6:0] ev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines come from flops, like peripheral logic sharing the clock
  always_ff @(posedge mclk_in) begin
    ev_out <= fire_in;
  end
endmodule : iga_event_src
`default_nettype wire

//--- tb/iga_aggregator_tb.sv
// iga_aggregator_tb.sv: self-checking bench for the event group aggregator
// assumes the design, its package and iga_event_src are compiled first
`default_nettype none
module iga_aggregator_tb;
  import iga_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       sel = 1'b0;
  logic       wr = 1'b0;
  iga_addr_t  addr = 8'h00;
  iga_word_t  wdata = 32'h0;
  iga_word_t  rdata;
  logic [6:0] fire = 7'h00;
  logic [6:0] ev;
  logic       irq_a;
  logic       irq_b;
  int         n_fail = 0;
  int         samples_checked = 0;
  initial forever #4 mclk_in = ~mclk_in;
  iga_event_src src (.mclk_in(mclk_in), .fire_in(fire), .ev_out(ev));
  iga_aggregator uut (.mclk_in(mclk_in), .reset_in(reset_in), .bus_sel_in(sel),
    .bus_wr_in(wr), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
    .event_group_a_in(ev[2:0]), .identification_done_event_in(ev[3]),
    .converter_single_done_in(ev[4]), .converter_repeat_done_in(ev[5]),
    .thermal_link_event_in(ev[6]), .event_group_a_irq_out(irq_a),
    .event_group_b_irq_out(irq_b));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one bus access, held until the taking edge
  task automatic acc(input logic w, input iga_addr_t a, input iga_word_t d);
    @(posedge mclk_in);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    sel <= 1'b0;
    #1;
  endtask : acc
  task automatic rd(input iga_addr_t a, input iga_word_t exp);
    acc(1'b0, a, 32'h0);
    chk("rdata", rdata, exp);
  endtask : rd
  // two-cycle event pulse, then settle
  task automatic fire_ev(input logic [6:0] f);
    @(posedge mclk_in);
    fire <= f;
    repeat (2) @(posedge mclk_in);
    fire <= 7'h00;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask : fire_ev
  task automatic t_reset;
    rd(8'h8c, 32'h0);
    rd(8'h90, 32'h0);
    rd(8'h94, 32'h0);
    rd(8'ha0, 32'h0);
  endtask : t_reset
  task automatic t_group_a;
    acc(1'b1, 8'h90, 32'hffff_ffff);
    rd(8'h90, 32'h0000_0007);
    acc(1'b1, 8'h94, 32'hffff_ffff);
    rd(8'h94, 32'h8000_0000);
    fire_ev(7'h07);
    rd(8'h8c, 32'h0000_0007);
    chk("irq_a", {31'h0, irq_a}, 32'h1);
    acc(1'b1, 8'h90, 32'h0000_0006);
    rd(8'h94, 32'h8000_0006);
    acc(1'b1, 8'h8c, 32'hffff_fffa);
    rd(8'h8c, 32'h0000_0005);
    acc(1'b1, 8'h8c, 32'h0000_0004);
    rd(8'h94, 32'h8000_0000);
    chk("irq_a", {31'h0, irq_a}, 32'h0);
  endtask : t_group_a
  task automatic t_group_b;
    @(posedge mclk_in);
    fire <= 7'h08;
    repeat (3) @(posedge mclk_in);
    rd(8'ha0, 32'h0000_0001);
    acc(1'b1, 8'ha0, 32'hffff_ffff);
    rd(8'ha0, 32'h0000_0000);
    fire_ev(7'h70);
    rd(8'ha0, 32'h0000_000e);
    chk("irq_b", {31'h0, irq_b}, 32'h1);
    acc(1'b1, 8'ha0, 32'hffff_ffff);
    rd(8'ha0, 32'h0000_0000);
    chk("irq_b", {31'h0, irq_b}, 32'h0);
    rd(8'h40, 32'h0000_0000);
  endtask : t_group_b
  // single place where the run ends
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset();
    t_group_a();
    t_group_b();
    tally_and_finish();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_fail++;
    tally_and_finish();
  end
endmodule : iga_aggregator_tb
`default_nettype wire
